// >>> verilog/fasl_top.v
/*
 * Fault alert conditioning and status latching for a power monitor:
 * comparator sync, enables, glitch filters, sticky status, command
 * decode for status access and two alert pins.
 * Assumes a protocol engine on the same clock hands over decoded
 * commands as one-cycle strobes, and raw comparators are asynchronous.
 */

// Functional notes
// - Filter select picks 0, 2, 4, 8 us
// - Faults pass only after persisting filter time
// - One undervoltage filter serves both pins
// - One overvoltage filter serves both pins
// - Overcurrent enable powers overcurrent comparator
// - Overvoltage enable powers overvoltage comparator
// - Undervoltage enable powers undervoltage comparator
// - Polarity bits set each pin's active level
// - Force bits drive each pin active
// - Clear-faults command zeroes all status except same-cycle sets
// - Overvoltage latches bus status bit 6
// - Undervoltage latches bus status bit 5
// - Overcurrent latches current status bit 5
// - Over-temperature latches temperature status bit 6
// - Unsupported command latches comm bit 7
// - Unsupported data latches comm bit 6
// - Packet check mismatch latches comm bit 5
// - Bypass bits choose filtered or raw path
// - Mask bits block latched sources; reset masks all
// - Other comm errors latch comm bit 1

`timescale 1ns/1ps
`include "fasl_regs.vh"

module fasl_top (
    // Clock and reset
    input  wire        i_mclk,
    input  wire        i_reset,
    // Raw comparator outputs, asynchronous
    input  wire        i_overvoltage_cmp,
    input  wire        i_undervoltage_cmp,
    input  wire        i_overcurrent_cmp,
    input  wire        i_overtemp_cmp,
    // Decoded command from protocol engine
    input  wire        i_cmd_valid,
    input  wire [1:0]  i_cmd_kind,
    input  wire [7:0]  i_cmd_code,
    input  wire        i_cmd_word,
    input  wire [15:0] i_cmd_data,
    input  wire        i_pec_error,
    // Read answer
    output reg  [15:0] o_rd_data,
    output reg         o_rd_valid,
    // Comparator power enables
    output wire        o_overvoltage_comparator_enable,
    output wire        o_undervoltage_comparator_enable,
    output wire        o_overcurrent_comparator_enable,
    // Alert pins
    output reg         o_push_pull_alert_pin,
    output reg         o_open_drain_alert_pin_out,
    output reg         o_open_drain_alert_pin_oe
);

    // Configuration and control registers
    reg  [15:0] cfg_q;          // Interrupt configuration word
    reg  [7:0]  fp_q;           // Force and polarity byte
    reg  [7:0]  mask1_q;        // First pin source mask
    reg  [7:0]  mask2_q;        // Second pin source mask
    reg  [7:0]  flag_q;         // Sticky sources, mask bit layout
    reg  [7:0]  flag_d;         // Next sticky sources

    // Synchroniser stages
    reg  [3:0]  sync1_q;        // First stage, read by second only
    reg  [3:0]  sync2_q;        // Second stage

    // Conditioned comparator paths
    wire [3:0]  raw_en;         // Enabled, synchronised comparators
    wire [3:0]  filt;           // Filtered comparators

    // Command decode results
    reg         clear_all;      // Clear-faults executed
    reg         ev_unsup_cmd;   // Unsupported command
    reg         ev_unsup_data;  // Unsupported data
    reg         ev_other_comm;  // Other comm error
    reg         wr_ok;          // Accepted register write
    reg         rd_ok;          // Accepted register read
    reg  [7:0]  clr;            // Write-one-to-clear per source
    reg  [15:0] rd_d;           // Read data mux
    reg  [7:0]  set;            // Set events per source

    // Alert combination
    wire        act1;           // First pin active before polarity
    wire        act2;           // Second pin active before polarity
    wire        lvl1;           // First pin level
    wire        lvl2;           // Second pin level

    // Filter select for one source
    function [1:0] filt_sel;
        input [15:0] cfg;
        input [1:0]  idx;
        begin
            case (idx)
                2'h0:    filt_sel = cfg[`FASL_CFG_OVERVOLTAGE_FILTER_SELECT_LSB +: 2];
                2'h1:    filt_sel = cfg[`FASL_CFG_UNDERVOLTAGE_FILTER_SELECT_LSB +: 2];
                2'h2:    filt_sel = cfg[`FASL_CFG_OVERCURRENT_FILTER_SELECT_LSB +: 2];
                default: filt_sel = cfg[`FASL_CFG_OVERVOLTAGE_FILTER_SELECT_LSB +: 2];   // Temperature shares overvoltage filter
            endcase
        end
    endfunction

    // Offset answers to a command
    function is_defined;
        input [7:0] a;
        begin
            case (a)
                `FASL_ADDR_MASK_FIRST, `FASL_ADDR_BUS_V_STATUS, `FASL_ADDR_SHUNT_I_STATUS,
                `FASL_ADDR_TEMP_STATUS, `FASL_ADDR_COMM_STATUS, `FASL_ADDR_CFG_INT,
                `FASL_ADDR_FORCE_POL, `FASL_ADDR_MASK_SECOND:
                    is_defined = 1'b1;
                default:
                    is_defined = 1'b0;
            endcase
        end
    endfunction

    // Active state of one pin before polarity
    function alert_act;
        input [7:0] flags;
        input [7:0] mask;
        input [2:0] ft;
        input [3:0] raw;
        reg         ov_t;
        reg         uv_t;
        reg         oc_t;
        reg         ot_t;
        begin
            ov_t = ft[`FASL_FT_OV_OT] ? raw[`FASL_SRC_OV] : (flags[`FASL_SRC_OV] & ~mask[`FASL_SRC_OV]);
            ot_t = ft[`FASL_FT_OV_OT] ? raw[`FASL_SRC_OT] : (flags[`FASL_SRC_OT] & ~mask[`FASL_SRC_OT]);
            uv_t = ft[`FASL_FT_UV] ? raw[`FASL_SRC_UV] : (flags[`FASL_SRC_UV] & ~mask[`FASL_SRC_UV]);
            oc_t = ft[`FASL_FT_OC] ? raw[`FASL_SRC_OC] : (flags[`FASL_SRC_OC] & ~mask[`FASL_SRC_OC]);

            alert_act = ov_t | ot_t | uv_t | oc_t | (|(flags[7:4] & ~mask[7:4]));
        end
    endfunction

    // Two-stage synchroniser for comparator pins
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= {i_overtemp_cmp, i_overcurrent_cmp, i_undervoltage_cmp, i_overvoltage_cmp};
            sync2_q <= sync1_q;
        end
    end

    // Enable gating; disabled comparator reads inactive
    assign raw_en[`FASL_SRC_OV] = sync2_q[`FASL_SRC_OV] & cfg_q[`FASL_CFG_OVERVOLTAGE_COMPARATOR_ENABLE];
    assign raw_en[`FASL_SRC_UV] = sync2_q[`FASL_SRC_UV] & cfg_q[`FASL_CFG_UNDERVOLTAGE_COMPARATOR_ENABLE];
    assign raw_en[`FASL_SRC_OC] = sync2_q[`FASL_SRC_OC] & cfg_q[`FASL_CFG_OVERCURRENT_COMPARATOR_ENABLE];
    assign raw_en[`FASL_SRC_OT] = sync2_q[`FASL_SRC_OT];

    // Power enables to the analog comparators
    assign o_overvoltage_comparator_enable  = cfg_q[`FASL_CFG_OVERVOLTAGE_COMPARATOR_ENABLE];
    assign o_undervoltage_comparator_enable = cfg_q[`FASL_CFG_UNDERVOLTAGE_COMPARATOR_ENABLE];
    assign o_overcurrent_comparator_enable  = cfg_q[`FASL_CFG_OVERCURRENT_COMPARATOR_ENABLE];

    // One shared filter per source, feeding both pins
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_filt
            fasl_glitch_filter u_filt (
                .i_mclk  (i_mclk),
                .i_reset (i_reset),
                .i_fault (raw_en[g]),
                .i_sel   (filt_sel(cfg_q, g[1:0])),
                .o_fault (filt[g])
            );
        end
    endgenerate

    // Command decode: errors, writes, reads, clear
    always @* begin
        clear_all     = 1'b0;
        ev_unsup_cmd  = 1'b0;
        ev_unsup_data = 1'b0;
        ev_other_comm = 1'b0;
        wr_ok         = 1'b0;
        rd_ok         = 1'b0;

        if (i_cmd_valid) begin
            case (i_cmd_kind)
                `FASL_KIND_SEND: begin
                    if (i_cmd_code == `FASL_CMD_CLEAR_FAULTS)
                        clear_all = 1'b1;
                    else
                        ev_unsup_cmd = 1'b1;
                end

                `FASL_KIND_WRITE: begin
                    if (i_cmd_code == `FASL_CMD_CLEAR_FAULTS)
                        ev_unsup_data = 1'b1;
                    else if (!is_defined(i_cmd_code))
                        ev_unsup_cmd = 1'b1;
                    else if (i_cmd_word != (i_cmd_code == `FASL_ADDR_CFG_INT))
                        ev_unsup_data = 1'b1;
                    else
                        wr_ok = 1'b1;
                end

                `FASL_KIND_READ: begin
                    if (i_cmd_code == `FASL_CMD_CLEAR_FAULTS)
                        ev_other_comm = 1'b1;
                    else if (!is_defined(i_cmd_code))
                        ev_unsup_cmd = 1'b1;
                    else
                        rd_ok = 1'b1;
                end

                default: begin
                    ev_unsup_cmd = 1'b1;
                end
            endcase
        end
    end

    // Write-one-to-clear decode per status byte
    always @* begin
        clr = 8'h00;
        if (wr_ok) begin
            case (i_cmd_code)
                `FASL_ADDR_BUS_V_STATUS: begin
                    clr[`FASL_SRC_OV] = i_cmd_data[`FASL_BIT_BUS_OV];
                    clr[`FASL_SRC_UV] = i_cmd_data[`FASL_BIT_BUS_UV];
                end
                `FASL_ADDR_SHUNT_I_STATUS: begin
                    clr[`FASL_SRC_OC] = i_cmd_data[`FASL_BIT_SHUNT_OC];
                end
                `FASL_ADDR_TEMP_STATUS: begin
                    clr[`FASL_SRC_OT] = i_cmd_data[`FASL_BIT_OVERTEMP];
                end
                `FASL_ADDR_COMM_STATUS: begin
                    clr[`FASL_SRC_UNSUP_CMD]  = i_cmd_data[`FASL_BIT_UNSUP_CMD];
                    clr[`FASL_SRC_UNSUP_DATA] = i_cmd_data[`FASL_BIT_UNSUP_DATA];
                    clr[`FASL_SRC_PEC]        = i_cmd_data[`FASL_BIT_PEC_ERR];
                    clr[`FASL_SRC_OTHER_COMM] = i_cmd_data[`FASL_BIT_OTHER_COMM];
                end
                default: begin
                    clr = 8'h00;
                end
            endcase
        end
    end

    // Sticky flags: a set in the clearing cycle wins
    always @* begin
        set = {ev_other_comm, i_pec_error, ev_unsup_data, ev_unsup_cmd, filt};
        flag_d = set | (flag_q & ~clr & {8{~clear_all}});
    end

    // Read data mux; reserved bits read zero
    always @* begin
        rd_d = 16'h0000;
        case (i_cmd_code)
            `FASL_ADDR_BUS_V_STATUS: begin
                rd_d[`FASL_BIT_BUS_OV] = flag_q[`FASL_SRC_OV];
                rd_d[`FASL_BIT_BUS_UV] = flag_q[`FASL_SRC_UV];
            end
            `FASL_ADDR_SHUNT_I_STATUS: begin
                rd_d[`FASL_BIT_SHUNT_OC] = flag_q[`FASL_SRC_OC];
            end
            `FASL_ADDR_TEMP_STATUS: begin
                rd_d[`FASL_BIT_OVERTEMP] = flag_q[`FASL_SRC_OT];
            end
            `FASL_ADDR_COMM_STATUS: begin
                rd_d[`FASL_BIT_UNSUP_CMD]  = flag_q[`FASL_SRC_UNSUP_CMD];
                rd_d[`FASL_BIT_UNSUP_DATA] = flag_q[`FASL_SRC_UNSUP_DATA];
                rd_d[`FASL_BIT_PEC_ERR]    = flag_q[`FASL_SRC_PEC];
                rd_d[`FASL_BIT_OTHER_COMM] = flag_q[`FASL_SRC_OTHER_COMM];
            end

            `FASL_ADDR_CFG_INT:     rd_d = {1'b0, cfg_q[14:0]};
            `FASL_ADDR_FORCE_POL:   rd_d = {8'h00, 4'h0, fp_q[3:0]};
            `FASL_ADDR_MASK_FIRST:  rd_d = {8'h00, mask1_q};
            `FASL_ADDR_MASK_SECOND: rd_d = {8'h00, mask2_q};
            default:                rd_d = 16'h0000;
        endcase
    end

    // Register file and status latches
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            cfg_q      <= `FASL_RST_CFG_INT;
            fp_q       <= `FASL_RST_FORCE_POL;
            mask1_q    <= `FASL_RST_MASK;
            mask2_q    <= `FASL_RST_MASK;
            flag_q     <= `FASL_RST_STATUS;
            o_rd_data  <= 16'h0000;
            o_rd_valid <= 1'b0;
        end else begin
            flag_q     <= flag_d;
            o_rd_valid <= rd_ok;
            if (rd_ok)
                o_rd_data <= rd_d;

            if (wr_ok) begin
                case (i_cmd_code)
                    `FASL_ADDR_CFG_INT:     cfg_q   <= {1'b0, i_cmd_data[14:0]};
                    `FASL_ADDR_FORCE_POL:   fp_q    <= {4'h0, i_cmd_data[3:0]};
                    `FASL_ADDR_MASK_FIRST:  mask1_q <= i_cmd_data[7:0];
                    `FASL_ADDR_MASK_SECOND: mask2_q <= i_cmd_data[7:0];
                    default:                cfg_q   <= cfg_q;
                endcase
            end
        end
    end

    // Pin activity: unmasked latched, bypassed raw, or forced
    assign act1 = alert_act(flag_q, mask1_q, cfg_q[`FASL_CFG_A1_FT_LSB +: 3], raw_en)
                  | fp_q[`FASL_FP_FORCE_FIRST];
    assign act2 = alert_act(flag_q, mask2_q, cfg_q[`FASL_CFG_A2_FT_LSB +: 3], raw_en)
                  | fp_q[`FASL_FP_FORCE_SECOND];

    assign lvl1 = fp_q[`FASL_FP_POL_FIRST] ? act1 : ~act1;
    assign lvl2 = fp_q[`FASL_FP_POL_SECOND] ? act2 : ~act2;

    // Pin drivers; open drain only ever pulls low
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_push_pull_alert_pin      <= 1'b1;
            o_open_drain_alert_pin_out <= 1'b0;
            o_open_drain_alert_pin_oe  <= 1'b0;
        end else begin
            o_push_pull_alert_pin      <= lvl2;
            o_open_drain_alert_pin_out <= 1'b0;
            o_open_drain_alert_pin_oe  <= ~lvl1;
        end
    end

endmodule

// >>> verilog/fasl_regs.vh
/*
 * Register offsets, field positions, reset values and timing values in ns
 * for the fault alert and status latching block.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef FASL_REGS_VH
`define FASL_REGS_VH

// Command codes and register offsets
`define FASL_CMD_CLEAR_FAULTS      8'h03
`define FASL_ADDR_MASK_FIRST       8'h1B
`define FASL_ADDR_BUS_V_STATUS     8'h7A
`define FASL_ADDR_SHUNT_I_STATUS   8'h7B
`define FASL_ADDR_TEMP_STATUS      8'h7D
`define FASL_ADDR_COMM_STATUS      8'h7E
`define FASL_ADDR_CFG_INT          8'hDD
`define FASL_ADDR_FORCE_POL        8'hDE
`define FASL_ADDR_MASK_SECOND      8'hDF

// Command kinds from the protocol engine
`define FASL_KIND_SEND             2'h0
`define FASL_KIND_WRITE            2'h1
`define FASL_KIND_READ             2'h2

// Status bit positions inside their bytes
`define FASL_BIT_BUS_OV            6
`define FASL_BIT_BUS_UV            5
`define FASL_BIT_SHUNT_OC          5
`define FASL_BIT_OVERTEMP          6
`define FASL_BIT_UNSUP_CMD         7
`define FASL_BIT_UNSUP_DATA        6
`define FASL_BIT_PEC_ERR           5
`define FASL_BIT_OTHER_COMM        1

// Interrupt configuration word fields
`define FASL_CFG_UNDERVOLTAGE_COMPARATOR_ENABLE             0
`define FASL_CFG_OVERVOLTAGE_COMPARATOR_ENABLE             1
`define FASL_CFG_OVERCURRENT_COMPARATOR_ENABLE             2
`define FASL_CFG_OVERVOLTAGE_FILTER_SELECT_LSB        3
`define FASL_CFG_UNDERVOLTAGE_FILTER_SELECT_LSB        5
`define FASL_CFG_OVERCURRENT_FILTER_SELECT_LSB        7
`define FASL_CFG_A1_FT_LSB         9
`define FASL_CFG_A2_FT_LSB         12
`define FASL_FT_OV_OT              2
`define FASL_FT_UV                 1
`define FASL_FT_OC                 0

// Force and polarity byte fields
`define FASL_FP_FORCE_FIRST        0
`define FASL_FP_FORCE_SECOND       1
`define FASL_FP_POL_FIRST          2
`define FASL_FP_POL_SECOND         3

// Internal source index (also mask bit layout)
`define FASL_SRC_OV                0
`define FASL_SRC_UV                1
`define FASL_SRC_OC                2
`define FASL_SRC_OT                3
`define FASL_SRC_UNSUP_CMD         4
`define FASL_SRC_UNSUP_DATA        5
`define FASL_SRC_PEC               6
`define FASL_SRC_OTHER_COMM        7

// Reset values
`define FASL_RST_CFG_INT           16'h0000
`define FASL_RST_FORCE_POL         8'h00
`define FASL_RST_MASK              8'hFF
`define FASL_RST_STATUS            8'h00

// Timing
`define FASL_CLK_PERIOD_NS         100
`define FASL_FILT_2US_NS           2000
`define FASL_FILT_4US_NS           4000
`define FASL_FILT_8US_NS           8000

`endif

// >>> verilog/fasl_glitch_filter.v
/*
 * One persistence filter: the output rises only after the input has
 * stayed high for the selected number of clock cycles.
 * Assumes a synchronised fault input and the 10 MHz block clock.
 */
`timescale 1ns/1ps
`include "fasl_regs.vh"

module fasl_glitch_filter (
    // Clock and reset
    input  wire       i_mclk,
    input  wire       i_reset,
    // Fault in and delay select
    input  wire       i_fault,
    input  wire [1:0] i_sel,
    // Filtered fault
    output reg        o_fault
);

    // Cycle counts, least times rounded up
    localparam integer CYC_2US = (`FASL_FILT_2US_NS + `FASL_CLK_PERIOD_NS - 1) / `FASL_CLK_PERIOD_NS;
    localparam integer CYC_4US = (`FASL_FILT_4US_NS + `FASL_CLK_PERIOD_NS - 1) / `FASL_CLK_PERIOD_NS;
    localparam integer CYC_8US = (`FASL_FILT_8US_NS + `FASL_CLK_PERIOD_NS - 1) / `FASL_CLK_PERIOD_NS;

    reg  [6:0] cnt_q;     // Cycles the fault has persisted
    reg  [6:0] lim;       // Last count before passing

    // Select to limit: none, 2, 4 or 8 us
    always @* begin
        case (i_sel)
            2'h0:    lim = 7'h00;
            2'h1:    lim = CYC_2US[6:0] - 7'h01;
            2'h2:    lim = CYC_4US[6:0] - 7'h01;
            2'h3:    lim = CYC_8US[6:0] - 7'h01;
            default: lim = 7'h00;
        endcase
    end

    // Persistence counter; any drop restarts it
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            cnt_q   <= 7'h00;
            o_fault <= 1'b0;
        end else if (!i_fault) begin
            cnt_q   <= 7'h00;
            o_fault <= 1'b0;
        end else if (cnt_q >= lim) begin
            o_fault <= 1'b1;
        end else begin
            cnt_q   <= cnt_q + 7'h01;
        end
    end

endmodule

// >>> verification/fasl_assertions.sv
/* Port-level checker for the fault alert block, bound to fasl_top.
   Assumes one clock domain and an async active-high reset. */
`timescale 1ns/1ps
module fasl_assertions (
    // Clock and reset
    input wire        i_mclk,
    input wire        i_reset,
    // Command port
    input wire        i_cmd_valid,
    input wire [1:0]  i_cmd_kind,
    input wire [7:0]  i_cmd_code,
    input wire        i_cmd_word,
    input wire [15:0] i_cmd_data,
    // Outputs watched
    input wire        o_rd_valid,
    input wire        o_overvoltage_comparator_enable,
    input wire        o_undervoltage_comparator_enable,
    input wire        o_overcurrent_comparator_enable,
    input wire        o_push_pull_alert_pin,
    input wire        o_open_drain_alert_pin_out,
    input wire        o_open_drain_alert_pin_oe
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    // Byte write to the force and polarity byte
    sequence fp_wr;
        i_cmd_valid && i_cmd_kind == 2'h1 && i_cmd_code == 8'hDE && !i_cmd_word;
    endsequence
    // Word write to the interrupt configuration
    sequence cfg_wr;
        i_cmd_valid && i_cmd_kind == 2'h1 && i_cmd_code == 8'hDD && i_cmd_word;
    endsequence
    force_first_a: assert property (fp_wr ##0 i_cmd_data[0] |-> ##2
        o_open_drain_alert_pin_oe == !$past(i_cmd_data[2], 2)) else $error("first pin not forced");
    force_second_a: assert property (fp_wr ##0 i_cmd_data[1] |-> ##2
        o_push_pull_alert_pin == $past(i_cmd_data[3], 2)) else $error("second pin not forced");
    ov_enable_a: assert property (cfg_wr |=>
        o_overvoltage_comparator_enable == $past(i_cmd_data[1])) else $error("ov enable wrong");
    uv_enable_a: assert property (cfg_wr |=>
        o_undervoltage_comparator_enable == $past(i_cmd_data[0])) else $error("uv enable wrong");
    oc_enable_a: assert property (cfg_wr |=>
        o_overcurrent_comparator_enable == $past(i_cmd_data[2])) else $error("oc enable wrong");
    wo_read_a: assert property (i_cmd_valid && i_cmd_kind == 2'h2 && i_cmd_code == 8'h03
        |=> !o_rd_valid) else $error("read of send-only code answered");
    status_read_a: assert property (i_cmd_valid && i_cmd_kind == 2'h2 && i_cmd_code == 8'h7E
        |=> o_rd_valid ##1 !o_rd_valid) else $error("status read not answered once");
    od_sink_a: assert property (!o_open_drain_alert_pin_out) else $error("open drain drives high");
    reset_idle_a: assert property ($fell(i_reset) |-> o_push_pull_alert_pin
        && !o_open_drain_alert_pin_oe) else $error("pins active after reset");
endmodule

bind fasl_top fasl_assertions u_chk (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_cmd_valid(i_cmd_valid), .i_cmd_kind(i_cmd_kind),
    .i_cmd_code(i_cmd_code), .i_cmd_word(i_cmd_word), .i_cmd_data(i_cmd_data), .o_rd_valid(o_rd_valid),
    .o_overvoltage_comparator_enable(o_overvoltage_comparator_enable),
    .o_undervoltage_comparator_enable(o_undervoltage_comparator_enable),
    .o_overcurrent_comparator_enable(o_overcurrent_comparator_enable),
    .o_push_pull_alert_pin(o_push_pull_alert_pin), .o_open_drain_alert_pin_out(o_open_drain_alert_pin_out),
    .o_open_drain_alert_pin_oe(o_open_drain_alert_pin_oe)
);

// >>> verification/fasl_host_model.sv
/* Bus host and alert-line listener facing the fault block.
   Assumes the 10 MHz clock and a pull-up on the open-drain alert. */
`timescale 1ns/1ps
module fasl_host_model (
    // Clock
    input  wire        i_mclk,
    // Command side
    output reg         o_cmd_valid,
    output reg  [1:0]  o_cmd_kind,
    output reg  [7:0]  o_cmd_code,
    output reg         o_cmd_word,
    output reg  [15:0] o_cmd_data,
    output reg         o_pec_error,
    // Answers and pins
    input  wire        i_rd_valid,
    input  wire [15:0] i_rd_data,
    input  wire        i_od_oe,
    output wire        o_od_level
);
    // Pull-up wins when nobody sinks the line
    assign o_od_level = i_od_oe ? 1'b0 : 1'b1;
    // Idle bus at time zero
    initial begin
        {o_cmd_valid, o_cmd_kind, o_cmd_code, o_cmd_word, o_cmd_data, o_pec_error} = 29'h0;
    end
    // One command, then scramble released fields
    task cmd(input [1:0] k, input [7:0] c, input w, input [15:0] d);
        begin
            @(posedge i_mclk);
            {o_cmd_valid, o_cmd_kind, o_cmd_code, o_cmd_word, o_cmd_data} <= {1'b1, k, c, w, d};
            @(posedge i_mclk);
            {o_cmd_valid, o_cmd_code, o_cmd_data} <= {1'b0, ~c, ~d};
        end
    endtask
    // Read: answer taken in the next cycle
    task rd(input [7:0] c, output v, output [15:0] d);
        begin
            cmd(2'h2, c, 1'b0, 16'h0000);
            @(negedge i_mclk);
            v = i_rd_valid;
            d = i_rd_data;
        end
    endtask
    // Clear-faults send byte carries no data
    task clear_faults;
        cmd(2'h0, 8'h03, 1'b0, 16'h0000);
    endtask
    // Packet check mismatch strobe
    task pec;
        begin
            @(posedge i_mclk) o_pec_error <= 1'b1;
            @(posedge i_mclk) o_pec_error <= 1'b0;
        end
    endtask
endmodule

// >>> verification/fasl_tb_top.sv
/* Self-checking bench for the fault alert block: the host model sends
   commands, the bench drives comparators and judges status and pins. */
`timescale 1ns/1ps
module fasl_tb_top;
    reg         mclk  = 1'b0; // 10 MHz clock
    reg         reset = 1'b1; // Async reset
    reg  [3:0]  cmp   = 4'h0; // OV, UV, OC, OT comparators
    wire        cv, cw, pe, rv, pp, odo, odoe, odl;
    wire [1:0]  ck;
    wire [7:0]  cc;
    wire [15:0] cd, rd;
    wire [2:0]  en;
    integer     n_errors = 0, checked = 0, cyc = 0, i, j, n;
    reg         v;
    reg  [15:0] d, cfg;
    always #50 mclk = ~mclk;
    fasl_top uut (.i_mclk(mclk), .i_reset(reset), .i_overvoltage_cmp(cmp[0]), .i_undervoltage_cmp(cmp[1]),
        .i_overcurrent_cmp(cmp[2]), .i_overtemp_cmp(cmp[3]), .i_cmd_valid(cv), .i_cmd_kind(ck),
        .i_cmd_code(cc), .i_cmd_word(cw), .i_cmd_data(cd), .i_pec_error(pe), .o_rd_data(rd), .o_rd_valid(rv),
        .o_overvoltage_comparator_enable(en[1]), .o_undervoltage_comparator_enable(en[0]),
        .o_overcurrent_comparator_enable(en[2]), .o_push_pull_alert_pin(pp),
        .o_open_drain_alert_pin_out(odo), .o_open_drain_alert_pin_oe(odoe));
    fasl_host_model host (.i_mclk(mclk), .o_cmd_valid(cv), .o_cmd_kind(ck), .o_cmd_code(cc), .o_cmd_word(cw),
        .o_cmd_data(cd), .o_pec_error(pe), .i_rd_valid(rv), .i_rd_data(rd), .i_od_oe(odoe), .o_od_level(odl));
    // Compare and count
    task chk(input [16:0] seen, input [16:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // Read that must be answered with the given value
    task rdchk(input [7:0] a, input [15:0] e);
        begin
            host.rd(a, v, d);
            chk({v, d}, {1'b1, e});
        end
    endtask
    task wr(input [7:0] a, input w, input [15:0] x);
        host.cmd(2'h1, a, w, x);
    endtask
    // Comparator high for m edges, then low and settle
    task hold(input integer k, input integer m);
        begin
            @(posedge mclk) cmp[k] <= 1'b1;
            repeat (m) @(posedge mclk);
            cmp[k] <= 1'b0;
            repeat (6) @(posedge mclk);
        end
    endtask
    task pins(input [1:0] e);
        begin
            repeat (5) @(posedge mclk);
            @(negedge mclk);
            chk({15'h0, odl, pp}, {15'h0, e});
        end
    endtask
    task t_reset;
        begin
            chk({12'h0, en, pp, odl}, 17'h00003);
            rdchk(8'h7A, 16'h0000);
            rdchk(8'h7E, 16'h0000);
            rdchk(8'hDE, 16'h0000);
            $display("t_reset done");
        end
    endtask
    task t_force;
        begin
            for (i = 0; i < 16; i = i + 1) begin
                wr(8'hDE, 1'b0, i[15:0]);
                pins({i[0] ~^ i[2], i[1] ~^ i[3]});
                rdchk(8'hDE, i[15:0]);
            end
            wr(8'hDE, 1'b0, 16'h0000);
            $display("t_force done");
        end
    endtask
    task t_filter;
        begin
            for (j = 0; j < 3; j = j + 1)
                for (i = 0; i < 4; i = i + 1) begin
                    n = (i == 0) ? 0 : 10 << i;
                    cfg = (j == 0) ? 16'h0002 : (j == 1) ? 16'h0001 : 16'h0004;
                    wr(8'hDD, 1'b1, cfg | (i[15:0] << (3 + 2 * j)));
                    if (n > 0) begin
                        hold(j, n - 1);
                        rdchk((j == 2) ? 8'h7B : 8'h7A, 16'h0000);
                    end
                    hold(j, n + 4);
                    rdchk((j == 2) ? 8'h7B : 8'h7A, (j == 0) ? 16'h0040 : 16'h0020);
                    wr((j == 2) ? 8'h7B : 8'h7A, 1'b0, 16'h00FF);
                    rdchk((j == 2) ? 8'h7B : 8'h7A, 16'h0000);
                end
            $display("t_filter done");
        end
    endtask
    task t_sources;
        begin
            wr(8'hDD, 1'b1, 16'h0000);
            for (j = 0; j < 3; j = j + 1) begin
                hold(j, 6);
                rdchk((j == 2) ? 8'h7B : 8'h7A, 16'h0000);
            end
            hold(3, 6);
            rdchk(8'h7D, 16'h0040);
            $display("t_sources done");
        end
    endtask
    task t_comm;
        begin
            host.cmd(2'h0, 8'h55, 1'b0, 16'h0000);
            wr(8'hDE, 1'b1, 16'h000F);
            host.pec;
            host.rd(8'h03, v, d);
            chk({16'h0, v}, 17'h0);
            rdchk(8'h7E, 16'h00E2);
            rdchk(8'hDE, 16'h0000);
            wr(8'h7E, 1'b0, 16'h0080);
            rdchk(8'h7E, 16'h0062);
            host.rd(8'h55, v, d);
            rdchk(8'h7E, 16'h00E2);
            host.clear_faults;
            rdchk(8'h7E, 16'h0000);
            rdchk(8'h7D, 16'h0000);
            $display("t_comm done");
        end
    endtask
    task t_mask;
        begin
            wr(8'hDD, 1'b1, 16'h4002);
            @(posedge mclk) cmp[0] <= 1'b1;
            pins(2'b10);
            @(posedge mclk) cmp[0] <= 1'b0;
            pins(2'b11);
            wr(8'h1B, 1'b0, 16'h00FE);
            pins(2'b01);
            wr(8'h7A, 1'b0, 16'h0040);
            pins(2'b11);
            $display("t_mask done");
        end
    endtask
    task summarize;
        begin
            $display("comparisons %0d, mismatches %0d", checked, n_errors);
            if (n_errors == 0 && checked > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // Hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            summarize;
        end
    end
    initial begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        @(negedge mclk);
        t_reset;
        t_force;
        t_filter;
        t_sources;
        t_comm;
        t_mask;
        summarize;
    end
endmodule
